// ===== core/cod_pkg.sv
// Package for the clock output divider: register map, field layout, timing constants
package cod_pkg;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

	// Field layout of output_clock_config
	localparam int CFG_W = 8;
	localparam int CFG_CLR_BIT = 7;
	localparam int CFG_INV_BIT = 6;
	localparam int CFG_SYM_BIT = 5;
	localparam int CFG_DIV_LSB = 0;
	localparam int DIV_W = 5;

	// Field layout of the control register
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_PORT_LSB = 1;
	localparam int PORT_W = 2;

	// Field layout of the status register
	localparam int STS_IDLE_BIT = 0;
	localparam int STS_RUN_BIT = 1;

	// Reset values
	localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;
	localparam logic [PORT_W-1:0] PORT_RESET = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

	// Factors up to this one pass the oscillator straight through
	localparam logic [DIV_W-1:0] DIV_PASS_MAX = 5'h01;

	// Half-period counter of the generator
	localparam int HCNT_W = DIV_W + 1;
	localparam logic [HCNT_W-1:0] HCNT_ONE = 6'h01;
	localparam logic [HCNT_W-1:0] HCNT_ZERO = 6'h00;

	// Timing: core clock and oscillator in MHz; half-period ticks need twice the rate
	localparam int CORE_MHZ = 125;
	localparam int OSC_MHZ = 24;
	localparam int ACC_W = 8;
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CORE_MHZ);
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * OSC_MHZ);
	localparam logic [ACC_W-1:0] ACC_ZERO = 8'h00;

	// Generator state
	typedef enum logic {
		COD_IDLE,
		COD_RUN
	} cod_state_e;

endpackage : cod_pkg

// ===== core/cod_avs.sv
// Avalon-MM slave handshake: one wait cycle, registered read data
`timescale 1ns/100ps
`default_nettype none
module cod_avs (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus side
	input wire logic avs_read,
	input wire logic avs_write,
	output logic [cod_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Register side
	input wire logic [cod_pkg::DATA_W-1:0] rd_value,
	output logic wr_stb
);
	import cod_pkg::*;

	logic req;

	assign req = avs_read | avs_write;
	// Write lands on the edge where the master sees waitrequest low
	assign wr_stb = avs_write & ~avs_waitrequest;

	// Waitrequest idles high; drops for one cycle after a request is seen
	always_ff @(posedge clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= RDATA_ZERO;
		end else if (avs_read & avs_waitrequest) begin
			avs_readdata <= rd_value;
		end
	end

endmodule : cod_avs
`default_nettype wire

// ===== core/cod_tick.sv
// Fractional rate generator: half-period ticks of the 24 MHz oscillator
`timescale 1ns/100ps
`default_nettype none
module cod_tick (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Tick output
	output logic half_tick
);
	import cod_pkg::*;

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic [ACC_W-1:0] acc_sum;
	logic wrap;

	// Average rate is exact; each tick jitters by one core cycle
	assign acc_sum = acc_q + ACC_STEP;
	assign wrap = (acc_sum >= ACC_MOD);
	assign acc_d = wrap ? (acc_sum - ACC_MOD) : acc_sum;

	always_ff @(posedge clk) begin
		if (srst) begin
			acc_q <= ACC_ZERO;
			half_tick <= 1'b0;
		end else begin
			acc_q <= acc_d;
			half_tick <= wrap;
		end
	end

endmodule : cod_tick
`default_nettype wire

// ===== core/cod_top.sv
// Clock output divider top: registers, period generator and output stage
//
// Functional notes
// - With duty balance set the output is high and low for equal halves at any factor.
// - With duty balance clear and odd factors of three or more the low part is one oscillator cycle shorter.
// - Factors zero and one pass the oscillator clock straight to the output.
// - Factors above one divide the oscillator by exactly that factor.
// - Clearing the enable lets the running period finish before the output idles.
// - The factor may be written any time and is used from the next period on.
// - The clear bit reads back whether the generator has reached idle or runs a pass-through factor.
// - Writing one to the clear bit resets the divider at once, output at its idle level (low unless the written inversion bit is set), new factor live.
// - The clear bit reads one when idle and zero while a factor of two or more runs.
// - Inversion is the last output stage, sets the idle level, and acts at once.
// - The output rate comes only from the oscillator, not from the system divider.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cod_top (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Avalon-MM slave
	input wire logic [cod_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [cod_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [cod_pkg::BE_W-1:0] AVS_BYTEENABLE,
	output logic [cod_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Generated clock toward the pins
	output logic CLK_OUT,
	output logic [cod_pkg::PORT_W-1:0] CLK_OUT_PORT_EN
);
	import cod_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// Factors below two behave as one
	function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] div);
		eff_div = (div <= DIV_PASS_MAX) ? DIV_PASS_MAX : div;
	endfunction : eff_div

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic wr_stb;
	logic lane0;
	logic wr_cfg;
	logic wr_ctl;
	logic clr_wr;
	logic [DATA_W-1:0] rd_value;
	logic [CFG_W-1:0] cfg_rd;
	logic [DATA_W-1:0] ctl_rd;
	logic [DATA_W-1:0] sts_rd;

	logic hit_cfg;
	logic hit_ctl;
	logic hit_sts;
	logic wr_inv;
	logic wr_sym;
	logic wr_en;
	logic [PORT_W-1:0] wr_port;

	logic idle_q;
	logic running_q;

	logic inv_q;
	logic sym_q;
	logic [DIV_W-1:0] div_q;
	logic en_q;
	logic [DIV_W-1:0] wr_div;

	logic half_tick;
	logic osc_phase_q;
	logic start_ok;
	logic go;

	cod_state_e state_q;
	cod_state_e state_d;
	logic [HCNT_W-1:0] hcnt_q;
	logic [HCNT_W-1:0] hcnt_d;
	logic [DIV_W-1:0] cur_div_q;
	logic [DIV_W-1:0] cur_div_d;
	logic cur_sym_q;
	logic cur_sym_d;

	logic [DIV_W-1:0] n_eff;
	logic pass;
	logic [HCNT_W-1:0] hcnt_last;
	logic [HCNT_W-1:0] low_len;
	logic period_end;
	logic running;
	logic idle;
	logic core_level;
	logic lvl_pass;
	logic lvl_div;

	////////////////////////////////////////////////////////////////////////
	// Bus slave and oscillator rate

	cod_avs u_avs (
		.clk(CORE_CLK),
		.srst(SRST),
		.avs_read(AVS_READ),
		.avs_write(AVS_WRITE),
		.avs_readdata(AVS_READDATA),
		.avs_waitrequest(AVS_WAITREQUEST),
		.rd_value(rd_value),
		.wr_stb(wr_stb)
	);

	// Rate is fixed to the oscillator, no system divider enters here
	cod_tick u_tick (
		.clk(CORE_CLK),
		.srst(SRST),
		.half_tick(half_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// One decode feeds both the write strobes and the read mux
	assign hit_cfg = reg_hit(AVS_ADDRESS, OFS_CONFIG);
	assign hit_ctl = reg_hit(AVS_ADDRESS, OFS_CONTROL);
	assign hit_sts = reg_hit(AVS_ADDRESS, OFS_STATUS);

	////////////////////////////////////////////////////////////////////////
	// Register writes

	assign lane0 = AVS_BYTEENABLE[0];
	assign wr_cfg = wr_stb & lane0 & hit_cfg;
	assign wr_ctl = wr_stb & lane0 & hit_ctl;
	assign clr_wr = wr_cfg & AVS_WRITEDATA[CFG_CLR_BIT];
	assign wr_div = AVS_WRITEDATA[CFG_DIV_LSB +: DIV_W];
	assign wr_inv = AVS_WRITEDATA[CFG_INV_BIT];
	assign wr_sym = AVS_WRITEDATA[CFG_SYM_BIT];
	assign wr_en = AVS_WRITEDATA[CTL_EN_BIT];
	assign wr_port = AVS_WRITEDATA[CTL_PORT_LSB +: PORT_W];

	// Factor is only staged here; the generator takes it at a boundary
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			inv_q <= 1'b0;
			sym_q <= 1'b0;
			div_q <= DIV_RESET;
		end else if (wr_cfg) begin
			inv_q <= wr_inv;
			sym_q <= wr_sym;
			div_q <= wr_div;
		end
	end

	// Enable and pin routing; routing is independent of the waveform enable
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			en_q <= 1'b0;
			CLK_OUT_PORT_EN <= PORT_RESET;
		end else if (wr_ctl) begin
			en_q <= wr_en;
			CLK_OUT_PORT_EN <= wr_port;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads

	// Top bit of the config word reads as the idle flag
	assign cfg_rd = {idle_q, inv_q, sym_q, div_q};
	assign ctl_rd = {{(DATA_W-PORT_W-1){1'b0}}, CLK_OUT_PORT_EN, en_q};
	assign sts_rd = {{(DATA_W-2){1'b0}}, running_q, idle_q};

	// Unmapped offsets read as zero
	assign rd_value = hit_cfg ? {{(DATA_W-CFG_W){1'b0}}, cfg_rd} :
		hit_ctl ? ctl_rd :
		hit_sts ? sts_rd : RDATA_ZERO;

	////////////////////////////////////////////////////////////////////////
	// Oscillator phase

	// Phase level mirrors the oscillator; a period always starts on its low half
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			osc_phase_q <= 1'b0;
		end else if (half_tick) begin
			osc_phase_q <= ~osc_phase_q;
		end
	end

	assign start_ok = half_tick & osc_phase_q;
	assign go = en_q & start_ok;

	////////////////////////////////////////////////////////////////////////
	// Period geometry

	assign n_eff = eff_div(cur_div_q);
	assign pass = (cur_div_q <= DIV_PASS_MAX);
	// Period is 2N half ticks, last index 2N-1
	assign hcnt_last = {n_eff, 1'b0} - HCNT_ONE;
	// Balanced: N halves low; otherwise whole cycles, low one shorter when odd
	assign low_len = cur_sym_q ? {1'b0, n_eff} : {1'b0, n_eff[DIV_W-1:1], 1'b0};
	assign period_end = half_tick & (hcnt_q == hcnt_last);

	assign running = (state_q == COD_RUN);
	// A running pass-through counts as idle for polling
	assign idle = ~(running & ~pass);

	////////////////////////////////////////////////////////////////////////
	// Status flags

	// Flags move with the output flop, so idle never reads ahead of the pin
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			idle_q <= 1'b1;
			running_q <= 1'b0;
		end else begin
			idle_q <= idle;
			running_q <= running;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Generator state machine

	always_comb begin
		state_d = state_q;
		hcnt_d = hcnt_q;
		cur_div_d = cur_div_q;
		cur_sym_d = cur_sym_q;
		case (state_q)
			COD_IDLE: begin
				// A clear while stopped only reloads the settings
				if (clr_wr) begin
					cur_div_d = wr_div;
					cur_sym_d = wr_sym;
					hcnt_d = HCNT_ZERO;
				end else if (go) begin
					state_d = COD_RUN;
					hcnt_d = HCNT_ZERO;
					cur_div_d = div_q;
					cur_sym_d = sym_q;
				end
			end
			COD_RUN: begin
				if (clr_wr) begin
					// Abandon the period, new factor takes over at once
					state_d = COD_IDLE;
					hcnt_d = HCNT_ZERO;
					cur_div_d = wr_div;
					cur_sym_d = wr_sym;
				end else if (period_end) begin
					hcnt_d = HCNT_ZERO;
					if (en_q) begin
						cur_div_d = div_q;
						cur_sym_d = sym_q;
					end else begin
						state_d = COD_IDLE;
					end
				end else if (half_tick) begin
					hcnt_d = hcnt_q + HCNT_ONE;
				end
			end
			default: begin
				state_d = COD_IDLE;
				hcnt_d = HCNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state_q <= COD_IDLE;
			hcnt_q <= HCNT_ZERO;
			cur_div_q <= DIV_RESET;
			cur_sym_q <= 1'b0;
		end else begin
			state_q <= state_d;
			hcnt_q <= hcnt_d;
			cur_div_q <= cur_div_d;
			cur_sym_q <= cur_sym_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage

	// Low part first; pass-through follows the oscillator phase
	assign lvl_pass = hcnt_q[0];
	assign lvl_div = (hcnt_q >= low_len);
	assign core_level = running & (pass ? lvl_pass : lvl_div);

	// Inversion sits last so a change shows at once, glitch possible
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			CLK_OUT <= 1'b0;
		end else begin
			CLK_OUT <= core_level ^ inv_q;
		end
	end

endmodule : cod_top
`default_nettype wire

// ===== test/cod_sva.sv
// Checker of the bus handshake and the output stage
`timescale 1ns/100ps
`default_nettype none
module cod_sva (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Bus
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Output
	input wire logic CLK_OUT,
	input wire logic [1:0] CLK_OUT_PORT_EN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	logic acc;
	logic ctl_q;
	logic [1:0] rt_q;
	assign acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	always_ff @(posedge CORE_CLK) begin
		ctl_q <= !SRST && acc && AVS_ADDRESS == 4'h4;
		rt_q <= AVS_WRITEDATA[2:1];
	end
	sequence s_taken;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_clr;
		acc && AVS_ADDRESS == 4'h0 && AVS_WRITEDATA[7:6] == 2'b10;
	endsequence
	a_wait_one: assert property (s_taken |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("wait not one cycle");
	a_wait_cause: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
		else $error("answer without request");
	a_unmapped_zero: assert property (s_taken and AVS_READ && AVS_ADDRESS > 4'h8
		|=> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
	a_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_rdata_hold: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
		else $error("read data moved");
	a_clr_low: assert property (s_clr |-> ##[1:2] !CLK_OUT)
		else $error("clear did not force low");
	a_route_set: assert property (ctl_q |-> CLK_OUT_PORT_EN == rt_q)
		else $error("routing not written");
	a_route_hold: assert property (!(acc && AVS_ADDRESS == 4'h4) |=> $stable(CLK_OUT_PORT_EN))
		else $error("routing moved");
endmodule : cod_sva
bind cod_top cod_sva u_sva (.CORE_CLK(CORE_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .CLK_OUT(CLK_OUT), .CLK_OUT_PORT_EN(CLK_OUT_PORT_EN));
`default_nettype wire

// ===== test/cod_sink.sv
// Clocked chip model: times the received clock in core cycles
`timescale 1ns/100ps
`default_nettype none
module cod_sink (
	// Clocks
	input wire logic clk,
	input wire logic clk_in,
	// Last measured lengths
	output int hi_len,
	output int lo_len,
	output int per_len
);
	int run = 0;
	logic last_q = 1'b0;
	always @(posedge clk) begin
		run <= run + 1;
		last_q <= clk_in;
		if (clk_in != last_q) begin
			run <= 1;
			if (last_q) hi_len <= run;
			else lo_len <= run;
			// Period runs low part first, so it closes on a fall
			if (last_q) per_len <= lo_len + run;
		end
	end
endmodule : cod_sink
`default_nettype wire

// ===== test/clock_output_divider_test.sv
// Testbench of the clock output divider
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("Error %0t got %h exp %h", $time, a, b); end end
module clock_output_divider_test;
	import cod_pkg::*;
	logic CORE_CLK = 1'b0;
	logic SRST = 1'b1;
	logic [3:0] AVS_ADDRESS = 4'h0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE = 4'h1;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic CLK_OUT;
	logic [1:0] CLK_OUT_PORT_EN;
	logic [31:0] q;
	int hi_len, lo_len, per_len;
	int num_errors = 0;
	int tests_run = 0;
	int fct[6] = '{0, 1, 2, 3, 7, 31};
	always #4 CORE_CLK = ~CORE_CLK;
	cod_top dut_u (.CORE_CLK(CORE_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .CLK_OUT(CLK_OUT), .CLK_OUT_PORT_EN(CLK_OUT_PORT_EN));
	cod_sink sink_u (.clk(CORE_CLK), .clk_in(CLK_OUT), .hi_len(hi_len), .lo_len(lo_len),
		.per_len(per_len));
	////////////////////////////////////////////////////////////////
	// Leading edge keeps a release and the next request apart
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do begin
			@(posedge CORE_CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : bus
	// Length in core cycles against half oscillator ticks; edges jitter a cycle each
	function automatic logic tol(input int c, input int h);
		return (c * 48 - h * 125 <= 96) && (h * 125 - c * 48 <= 96);
	endfunction : tol
	task automatic wait_per();
		@(negedge CLK_OUT);
		repeat (2) @(posedge CORE_CLK);
	endtask : wait_per
	task automatic t_reset();
		bus(0, 4'h0, 0);
		`CHK(q, 32'h0000_0080)
		bus(0, 4'h8, 0);
		`CHK(q, 32'h0000_0001)
		bus(0, 4'hC, 0);
		`CHK(q, 32'h0000_0000)
	endtask : t_reset
	task automatic t_rates();
		bus(1, 4'h0, 32'h0000_0003);
		bus(1, 4'h4, 32'h0000_0007);
		@(posedge CORE_CLK);
		`CHK(CLK_OUT_PORT_EN, 2'h3)
		foreach (fct[i]) begin
			// Third fall closes a whole period even if the clear cut a high part
			bus(1, 4'h0, 32'h80 | fct[i]);
			wait_per();
			wait_per();
			wait_per();
			`CHK(tol(per_len, fct[i] < 2 ? 2 : 2 * fct[i]), 1'b1)
			if (fct[i] == 3) `CHK(tol(lo_len, 2) && tol(hi_len, 4), 1'b1)
		end
		bus(1, 4'h0, 32'h0000_00A3);
		wait_per();
		wait_per();
		wait_per();
		`CHK(tol(lo_len, 3) && tol(hi_len, 3), 1'b1)
		`CHK(tol(per_len, 6), 1'b1)
	endtask : t_rates
	task automatic t_switch();
		bus(1, 4'h0, 32'h0000_0083);
		wait_per();
		wait_per();
		bus(1, 4'h0, 32'h0000_0007);
		wait_per();
		`CHK(tol(per_len, 6), 1'b1)
		wait_per();
		`CHK(tol(per_len, 14), 1'b1)
	endtask : t_switch
	task automatic t_stop();
		int n;
		@(posedge CLK_OUT);
		@(posedge CORE_CLK);
		bus(1, 4'h4, 32'h0000_0006);
		`CHK(CLK_OUT, 1'b1)
		bus(0, 4'h0, 0);
		`CHK(q[7], 1'b0)
		n = 0;
		while (q[7] !== 1'b1 && n < 60) begin
			bus(0, 4'h0, 0);
			n++;
		end
		`CHK(q[7], 1'b1)
		`CHK(CLK_OUT, 1'b0)
		bus(1, 4'h0, 32'h0000_0047);
		repeat (3) @(posedge CORE_CLK);
		`CHK(CLK_OUT, 1'b1)
	endtask : t_stop
	task automatic t_clear();
		bus(1, 4'h0, 32'h0000_0007);
		bus(1, 4'h4, 32'h0000_0001);
		@(posedge CLK_OUT);
		@(posedge CORE_CLK);
		bus(1, 4'h0, 32'h0000_0082);
		repeat (2) @(posedge CORE_CLK);
		`CHK(CLK_OUT, 1'b0)
		wait_per();
		wait_per();
		`CHK(tol(per_len, 4), 1'b1)
		AVS_BYTEENABLE <= 4'h0;
		bus(1, 4'h0, 32'h0000_001F);
		AVS_BYTEENABLE <= 4'h1;
		bus(0, 4'h0, 0);
		`CHK(q[4:0], 5'h02)
	endtask : t_clear
	task automatic stop_test();
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(posedge CORE_CLK);
		SRST <= 1'b0;
		@(posedge CORE_CLK);
		t_reset();
		t_rates();
		t_switch();
		t_stop();
		t_clear();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		num_errors++;
		stop_test();
	end
endmodule : clock_output_divider_test
`default_nettype wire
